/* src/range_and_signed_compare.sv */
// Range check and signed compare datapath with flags and a register port.
// Assumes the sequencer holds operands stable in the cycle of issue and
// that pointer and area faults come from the operand fetch on this clock.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module range_and_signed_compare #(
    parameter int WORD_W = cmp_pkg::WORD_W
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic clkEn,
    input wire logic issue,
    input wire logic execCond,
    input wire logic [cmp_pkg::FUNC_W-1:0] funcCode,
    input wire logic [2*WORD_W-1:0] compareValue,
    input wire logic [2*WORD_W-1:0] lowerLimit,
    input wire logic [2*WORD_W-1:0] upperLimit,
    input wire logic [WORD_W-1:0] firstOperand,
    input wire logic [WORD_W-1:0] secondOperand,
    input wire logic pointerNotBcd,
    input wire logic areaOverrun,
    input wire logic [cmp_pkg::ADDR_W-1:0] regAddr,
    input wire logic [WORD_W-1:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [WORD_W-1:0] regRdData,
    output logic greaterFlag,
    output logic equalFlag,
    output logic lessFlag,
    output logic errorFlag,
    output logic [WORD_W-1:0] specialStatus,
    output logic irq
);
    // ========================================
    // Elaboration check
    if (WORD_W < cmp_pkg::LESS_BIT + 1 || WORD_W < cmp_pkg::FUNC_W)
    begin : gBadWord
        $error("WORD_W too narrow for flag bits or function codes");
    end

    localparam int DW = 2 * WORD_W;
    localparam int NCMP = 4;

    // ========================================
    // State of the block
    typedef struct packed {
        logic greater;
        logic equal;
        logic less;
        logic error;
        logic [cmp_pkg::FUNC_W-1:0] code16;
        logic [cmp_pkg::FUNC_W-1:0] code32;
        logic [cmp_pkg::FUNC_W-1:0] codeSigned;
        logic [cmp_pkg::IRQ_W-1:0] irqStatus;
        logic [cmp_pkg::IRQ_W-1:0] irqMask;
        logic [WORD_W-1:0] readData;
    } state_t;

    state_t s;
    state_t next_s;

    // ========================================
    // Decode, range 16 wins if software maps two ops to one code
    cmp_pkg::op_t op;
    always_comb begin
        if (funcCode == s.code16) begin
            op = cmp_pkg::OP_RANGE16;
        end else if (funcCode == s.code32) begin
            op = cmp_pkg::OP_RANGE32;
        end else if (funcCode == s.codeSigned) begin
            op = cmp_pkg::OP_SIGNED;
        end else begin
            op = cmp_pkg::OP_NONE;
        end
    end

    // ========================================
    // Operand steering; 16-bit range uses the low words zero extended
    logic [DW-1:0] valueX;
    logic [DW-1:0] lowX;
    logic [DW-1:0] upX;
    always_comb begin
        if (op == cmp_pkg::OP_RANGE32) begin
            valueX = compareValue;
            lowX = lowerLimit;
            upX = upperLimit;
        end else begin
            valueX = {{WORD_W{1'b0}}, compareValue[WORD_W-1:0]};
            lowX = {{WORD_W{1'b0}}, lowerLimit[WORD_W-1:0]};
            upX = {{WORD_W{1'b0}}, upperLimit[WORD_W-1:0]};
        end
    end

    // Signed operands sign extended to the comparator width
    logic [DW-1:0] firstX;
    logic [DW-1:0] secondX;
    assign firstX = {{WORD_W{firstOperand[WORD_W-1]}}, firstOperand};
    assign secondX = {{WORD_W{secondOperand[WORD_W-1]}}, secondOperand};

    // ========================================
    // Four comparators: value-low, value-up, low-up, first-second
    logic [DW-1:0] cmpA [NCMP];
    logic [DW-1:0] cmpB [NCMP];
    logic [NCMP-1:0] cmpSigned;
    logic [NCMP-1:0] cmpLt;
    logic [NCMP-1:0] cmpEq;
    logic [NCMP-1:0] cmpGt;
    assign cmpA[0] = valueX;
    assign cmpB[0] = lowX;
    assign cmpA[1] = valueX;
    assign cmpB[1] = upX;
    assign cmpA[2] = lowX;
    assign cmpB[2] = upX;
    assign cmpA[3] = firstX;
    assign cmpB[3] = secondX;
    assign cmpSigned = 4'h8; // Only the last one is signed

    for (genvar i = 0; i < NCMP; i++) begin : gCmp
        mag_compare #(
            .WIDTH(DW)
        ) uCmp (
            .a(cmpA[i]),
            .b(cmpB[i]),
            .isSigned(cmpSigned[i]),
            .lt(cmpLt[i]),
            .eq(cmpEq[i]),
            .gt(cmpGt[i])
        );
    end

    // ========================================
    // Execution qualifiers
    logic run;
    logic isRange;
    logic indirectFault;
    logic limitFault;
    logic anyFault;
    assign run = clkEn && issue && execCond
        && (op != cmp_pkg::OP_NONE);
    assign isRange = (op == cmp_pkg::OP_RANGE16)
        || (op == cmp_pkg::OP_RANGE32);
    assign indirectFault = pointerNotBcd || areaOverrun;
    assign limitFault = isRange && cmpGt[2];
    assign anyFault = indirectFault || limitFault;

    // ========================================
    // Next state: flags, register port, interrupt status
    logic [cmp_pkg::IRQ_W-1:0] events;
    always_comb begin
        next_s = s;
        events = '0;
        if (clkEn) begin
            next_s.readData = '0;
            if (run) begin
                events[cmp_pkg::IRQ_DONE] = 1'b1;
                // A fault leaves the result flags as they were
                if (anyFault) begin
                    next_s.error = 1'b1;
                    events[cmp_pkg::IRQ_ERR] = 1'b1;
                end else begin
                    next_s.error = 1'b0;
                    unique case (op)
                        cmp_pkg::OP_RANGE16, cmp_pkg::OP_RANGE32: begin
                            next_s.less = cmpLt[0];
                            next_s.greater = cmpGt[1];
                            next_s.equal = !cmpLt[0] && !cmpGt[1];
                        end
                        cmp_pkg::OP_SIGNED: begin
                            next_s.less = cmpLt[3];
                            next_s.greater = cmpGt[3];
                            next_s.equal = cmpEq[3];
                        end
                        default: begin
                            next_s.less = s.less;
                        end
                    endcase
                end
            end
            // Register writes
            if (regWr) begin
                unique case (regAddr)
                    cmp_pkg::REG_CODE16: begin
                        next_s.code16 = regWrData[cmp_pkg::FUNC_W-1:0];
                    end
                    cmp_pkg::REG_CODE32: begin
                        next_s.code32 = regWrData[cmp_pkg::FUNC_W-1:0];
                    end
                    cmp_pkg::REG_CODESGN: begin
                        next_s.codeSigned = regWrData[cmp_pkg::FUNC_W-1:0];
                    end
                    cmp_pkg::REG_IRQMASK: begin
                        next_s.irqMask = regWrData[cmp_pkg::IRQ_W-1:0];
                    end
                    default: begin
                        next_s.irqMask = s.irqMask;
                    end
                endcase
            end
            // Register reads; unmapped addresses read zero
            if (regRd) begin
                unique case (regAddr)
                    cmp_pkg::REG_FLAGS: begin
                        next_s.readData = specialStatus;
                    end
                    cmp_pkg::REG_CODE16: begin
                        next_s.readData[cmp_pkg::FUNC_W-1:0] = s.code16;
                    end
                    cmp_pkg::REG_CODE32: begin
                        next_s.readData[cmp_pkg::FUNC_W-1:0] = s.code32;
                    end
                    cmp_pkg::REG_CODESGN: begin
                        next_s.readData[cmp_pkg::FUNC_W-1:0] = s.codeSigned;
                    end
                    cmp_pkg::REG_IRQSTAT: begin
                        next_s.readData[cmp_pkg::IRQ_W-1:0] = s.irqStatus;
                    end
                    cmp_pkg::REG_IRQMASK: begin
                        next_s.readData[cmp_pkg::IRQ_W-1:0] = s.irqMask;
                    end
                    default: begin
                        next_s.readData = '0;
                    end
                endcase
            end
            // Read clears status; a same-cycle event still sets its bit
            if (regRd && regAddr == cmp_pkg::REG_IRQSTAT) begin
                next_s.irqStatus = events;
            end else begin
                next_s.irqStatus = s.irqStatus | events;
            end
        end
    end

    // ========================================
    // State register, synchronous reset
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s <= '{greater: 1'b0, equal: 1'b0, less: 1'b0, error: 1'b0,
                code16: cmp_pkg::CODE_RANGE16_RST,
                code32: cmp_pkg::CODE_RANGE32_RST,
                codeSigned: cmp_pkg::CODE_SIGNED_RST,
                irqStatus: '0, irqMask: cmp_pkg::IRQ_MASK_RST,
                readData: '0};
        end else begin
            s <= next_s;
        end
    end

    // ========================================
    // Outputs straight from flops; irq ORs the masked status flops
    always_comb begin
        specialStatus = '0;
        specialStatus[cmp_pkg::GREATER_BIT] = s.greater;
        specialStatus[cmp_pkg::EQUAL_BIT] = s.equal;
        specialStatus[cmp_pkg::LESS_BIT] = s.less;
        specialStatus[cmp_pkg::ERROR_BIT] = s.error;
    end
    assign greaterFlag = s.greater;
    assign equalFlag = s.equal;
    assign lessFlag = s.less;
    assign errorFlag = s.error;
    assign regRdData = s.readData;
    assign irq = |(s.irqStatus & s.irqMask);

    // ========================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence sRun(cmp_pkg::op_t k);
        run && op == k && !anyFault;
    endsequence

    sequence sResult(logic g, logic e, logic l);
        greaterFlag == g && equalFlag == e && lessFlag == l && !errorFlag;
    endsequence

    a_idle_flags_hold: assert property (
        !run |=> $stable({greaterFlag, equalFlag, lessFlag, errorFlag}))
        else $error("flags moved without an executed compare");

    a_status_bit_map: assert property (
        specialStatus[cmp_pkg::GREATER_BIT] == greaterFlag
        && specialStatus[cmp_pkg::EQUAL_BIT] == equalFlag
        && specialStatus[cmp_pkg::LESS_BIT] == lessFlag)
        else $error("special status bits do not match flags");

    a_range_below: assert property (
        sRun(cmp_pkg::OP_RANGE16)
        and (compareValue[WORD_W-1:0] < lowerLimit[WORD_W-1:0])
        |=> sResult(1'b0, 1'b0, 1'b1))
        else $error("range check below limit gave wrong flags");

    a_range_inside: assert property (
        sRun(cmp_pkg::OP_RANGE16)
        and (compareValue[WORD_W-1:0] >= lowerLimit[WORD_W-1:0])
        and (compareValue[WORD_W-1:0] <= upperLimit[WORD_W-1:0])
        |=> sResult(1'b0, 1'b1, 1'b0))
        else $error("range check inside limits gave wrong flags");

    a_limit_error: assert property (
        run && op == cmp_pkg::OP_RANGE16
        && lowerLimit[WORD_W-1:0] > upperLimit[WORD_W-1:0]
        |=> errorFlag && $stable({greaterFlag, equalFlag, lessFlag}))
        else $error("inverted 16-bit limits did not raise error");

    a_indirect_error: assert property (
        run && (pointerNotBcd || areaOverrun)
        |=> errorFlag && $stable({greaterFlag, equalFlag, lessFlag}))
        else $error("indirect fault did not raise error");

    a_pair_above: assert property (
        sRun(cmp_pkg::OP_RANGE32) and (compareValue > upperLimit)
        |=> sResult(1'b1, 1'b0, 1'b0))
        else $error("32-bit range above limit gave wrong flags");

    a_pair_limit: assert property (
        run && op == cmp_pkg::OP_RANGE32 && lowerLimit > upperLimit
        |=> errorFlag)
        else $error("inverted 32-bit limits did not raise error");

    a_signed_order: assert property (
        sRun(cmp_pkg::OP_SIGNED)
        and ($signed(firstOperand) < $signed(secondOperand))
        |=> sResult(1'b0, 1'b0, 1'b1))
        else $error("signed compare less gave wrong flags");

    a_unsigned_range: assert property (
        sRun(cmp_pkg::OP_RANGE16) and compareValue[WORD_W-1]
        and !upperLimit[WORD_W-1]
        |=> greaterFlag)
        else $error("range check did not order values unsigned");

    a_code_remap: assert property (
        clkEn && regWr && regAddr == cmp_pkg::REG_CODE16
        |=> s.code16 == $past(regWrData[cmp_pkg::FUNC_W-1:0]))
        else $error("function code was not reassigned");

    a_flags_onehot: assert property (
        $onehot0({greaterFlag, equalFlag, lessFlag}))
        else $error("result flags not mutually exclusive");
endmodule : range_and_signed_compare

/* src/cmp_pkg.sv */
// Constants and types shared by the range and signed compare datapath.
// Assumes one clock domain; the sequencer supplies operands and a strobe.
package cmp_pkg;
    // ========================================
    // Widths
    localparam int WORD_W = 16;
    localparam int FUNC_W = 12;
    localparam int ADDR_W = 8;
    localparam int IRQ_W = 2;

    // ========================================
    // Default function codes, three BCD digits
    localparam logic [FUNC_W-1:0] CODE_RANGE16_RST = 12'h088;
    localparam logic [FUNC_W-1:0] CODE_RANGE32_RST = 12'h116;
    localparam logic [FUNC_W-1:0] CODE_SIGNED_RST = 12'h114;

    // ========================================
    // Flag positions inside special status word 255
    localparam int STATUS_WORD = 255;
    localparam int ERROR_BIT = 3;
    localparam int GREATER_BIT = 5;
    localparam int EQUAL_BIT = 6;
    localparam int LESS_BIT = 7;

    // ========================================
    // Register map of the plain register port
    localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h00;
    localparam logic [ADDR_W-1:0] REG_CODE16 = 8'h04;
    localparam logic [ADDR_W-1:0] REG_CODE32 = 8'h08;
    localparam logic [ADDR_W-1:0] REG_CODESGN = 8'h0C;
    localparam logic [ADDR_W-1:0] REG_IRQSTAT = 8'h10;
    localparam logic [ADDR_W-1:0] REG_IRQMASK = 8'h14;

    // Interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;

    // ========================================
    // Decoded operation, Gray coded along none, 16, 32, signed
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_RANGE16 = 2'b01,
        OP_RANGE32 = 2'b11,
        OP_SIGNED = 2'b10
    } op_t;
endpackage : cmp_pkg

/* src/mag_compare.sv */
// Combinational magnitude comparator, signed or unsigned per call.
// Assumes operands are already extended to the full width.
`timescale 1ns/1ps
module mag_compare #(
    parameter int WIDTH = 32
) (
    input wire logic [WIDTH-1:0] a,
    input wire logic [WIDTH-1:0] b,
    input wire logic isSigned,
    output logic lt,
    output logic eq,
    output logic gt
);
    // ========================================
    // Elaboration check
    if (WIDTH < 2) begin : gBadWidth
        $error("mag_compare needs WIDTH of at least 2");
    end

    // ========================================
    // Flipping the sign bits turns a signed order into an unsigned one
    logic [WIDTH-1:0] aKey;
    logic [WIDTH-1:0] bKey;
    always_comb begin
        aKey = a;
        bKey = b;
        if (isSigned) begin
            aKey[WIDTH-1] = ~a[WIDTH-1];
            bKey[WIDTH-1] = ~b[WIDTH-1];
        end
        lt = aKey < bKey;
        eq = aKey == bKey;
        gt = aKey > bKey;
    end
endmodule : mag_compare

/* dv/op_sequencer_model.sv */
// Behavioural model of the instruction sequencer and operand fetch logic.
// Assumes one caller at a time, on the same clock as the comparator.
`timescale 1ns/1ps
module op_sequencer_model (
    input wire logic ref_clk,
    output logic issue,
    output logic execCond,
    output logic [cmp_pkg::FUNC_W-1:0] funcCode,
    output logic [2*cmp_pkg::WORD_W-1:0] compareValue,
    output logic [2*cmp_pkg::WORD_W-1:0] lowerLimit,
    output logic [2*cmp_pkg::WORD_W-1:0] upperLimit,
    output logic [cmp_pkg::WORD_W-1:0] firstOperand,
    output logic [cmp_pkg::WORD_W-1:0] secondOperand,
    output logic pointerNotBcd,
    output logic areaOverrun
);
    // ========================================
    // Idle state
    // Lines start quiet so reset sees no instruction
    initial begin
        issue = 1'b0;
        execCond = 1'b0;
        funcCode = '0;
        compareValue = '0;
        lowerLimit = '0;
        upperLimit = '0;
        firstOperand = '0;
        secondOperand = '0;
        pointerNotBcd = 1'b0;
        areaOverrun = 1'b0;
    end

    // ========================================
    // Issue one instruction
    // Limits come as the caller orders; a lower limit above the upper one
    // is only sent when a scenario asks for it
    // Each word pair is fetched from one area; a crossing is reported on
    // the overrun line, a pointer word that is not BCD on the pointerNotBcd line
    // Third operand of the signed compare is encoded as zero and never
    // reaches a port
    // Operand lines show the inverse once released, so a stale value
    // cannot pass for a held one
    task automatic run_op(input logic [11:0] code, input logic cond,
                          input logic [31:0] cv, input logic [31:0] ll,
                          input logic [31:0] ul, input logic [15:0] p1,
                          input logic [15:0] p2, input logic [1:0] fault);
        @(posedge ref_clk);
        issue <= 1'b1;
        execCond <= cond;
        funcCode <= code;
        compareValue <= cv;
        lowerLimit <= ll;
        upperLimit <= ul;
        firstOperand <= p1;
        secondOperand <= p2;
        pointerNotBcd <= fault[0];
        areaOverrun <= fault[1];
        @(posedge ref_clk);
        issue <= 1'b0;
        execCond <= ~cond;
        funcCode <= ~code;
        compareValue <= ~cv;
        lowerLimit <= ~ll;
        upperLimit <= ~ul;
        firstOperand <= ~p1;
        secondOperand <= ~p2;
        pointerNotBcd <= ~fault[0];
        areaOverrun <= ~fault[1];
    endtask : run_op
endmodule : op_sequencer_model

/* dv/range_and_signed_compare_tb_top.sv */
// Self-checking bench for the range and signed compare datapath.
// Assumes the sequencer model drives the compare port; the bench owns the
// register port, clock enable and reset. Flags are read right after each
// compare, before another one can overwrite them
`timescale 1ns/1ps
module range_and_signed_compare_tb_top;
    localparam logic [11:0] R16 = cmp_pkg::CODE_RANGE16_RST;
    localparam logic [11:0] R32 = cmp_pkg::CODE_RANGE32_RST;
    localparam logic [11:0] SGN = cmp_pkg::CODE_SIGNED_RST;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clkEn = 1'b1;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regAddr = '0;
    logic [15:0] regWrData = '0;
    logic [15:0] regRdData, specialStatus;
    logic issue, execCond, pointerNotBcd, areaOverrun, irq;
    logic greaterFlag, equalFlag, lessFlag, errorFlag;
    logic [11:0] funcCode;
    logic [31:0] compareValue, lowerLimit, upperLimit;
    logic [15:0] firstOperand, secondOperand;
    int num_errors = 0;
    int check_count = 0;

    // ========================================
    // Clock, design and far side
    always #2.5 ref_clk = ~ref_clk;

    range_and_signed_compare dut_u (.ref_clk(ref_clk), .rst_b(rst_b),
        .clkEn(clkEn), .issue(issue), .execCond(execCond),
        .funcCode(funcCode), .compareValue(compareValue),
        .lowerLimit(lowerLimit), .upperLimit(upperLimit),
        .firstOperand(firstOperand), .secondOperand(secondOperand),
        .pointerNotBcd(pointerNotBcd), .areaOverrun(areaOverrun),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
        .regRd(regRd), .regRdData(regRdData), .greaterFlag(greaterFlag),
        .equalFlag(equalFlag), .lessFlag(lessFlag), .errorFlag(errorFlag),
        .specialStatus(specialStatus), .irq(irq));

    op_sequencer_model seq_u (.ref_clk(ref_clk), .issue(issue),
        .execCond(execCond), .funcCode(funcCode),
        .compareValue(compareValue), .lowerLimit(lowerLimit),
        .upperLimit(upperLimit), .firstOperand(firstOperand),
        .secondOperand(secondOperand), .pointerNotBcd(pointerNotBcd),
        .areaOverrun(areaOverrun));

    // ========================================
    // Shared tasks
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Expected flags packed as greater, equal, less, error
    task automatic check_flags(input logic [3:0] f);
        logic [15:0] img;
        img = 16'(f[3]) << cmp_pkg::GREATER_BIT;
        img |= 16'(f[2]) << cmp_pkg::EQUAL_BIT;
        img |= 16'(f[1]) << cmp_pkg::LESS_BIT;
        img |= 16'(f[0]) << cmp_pkg::ERROR_BIT;
        check("flags", 32'(f), {greaterFlag, equalFlag, lessFlag, errorFlag});
        check("status word", 32'(img), 32'(specialStatus));
    endtask : check_flags

    // Flags are checked 1 ns after the edge that takes the instruction
    task automatic op(input logic [11:0] code, input logic cond,
                      input logic [31:0] cv, input logic [31:0] ll,
                      input logic [31:0] ul, input logic [15:0] p1,
                      input logic [15:0] p2, input logic [1:0] fault,
                      input logic [3:0] f);
        seq_u.run_op(code, cond, cv, ll, ul, p1, p2, fault);
        #1;
        check_flags(f);
    endtask : op

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        regWrData <= ~d;
    endtask : reg_write

    // Read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        check("read data", 32'(exp), 32'(regRdData));
    endtask : reg_read

    task automatic tally_and_finish;
        $display("Checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish

    // ========================================
    // Watchdog against a hung sequence
    initial begin
        repeat (3000) @(posedge ref_clk);
        num_errors++;
        $display("Error watchdog expected end seen hang");
        tally_and_finish();
    end

    // ========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1;
        check_flags(4'h0);
        reg_read(cmp_pkg::REG_CODE16, 16'h0088);
        reg_read(cmp_pkg::REG_CODE32, 16'h0116);
        reg_read(cmp_pkg::REG_CODESGN, 16'h0114);
        reg_read(cmp_pkg::REG_IRQMASK, 16'h0000);
        reg_read(8'h20, 16'h0000);
        // Upper halves are junk: the short check must ignore them
        op(R16, 1, 32'hFFFF_000F, 32'h5A5A_0010, 32'h0000_AB1F,
            0, 0, 0, 4'h2);
        op(R16, 1, 32'h0000_0010, 32'h0000_0010, 32'hFFFF_AB1F,
            0, 0, 0, 4'h4);
        op(R16, 1, 32'h0000_AB1F, 32'h0000_0010, 32'h0000_AB1F,
            0, 0, 0, 4'h4);
        op(R16, 1, 32'h0000_8000, 32'h0000_0010, 32'h0000_AB1F,
            0, 0, 0, 4'h4);
        // Signed order would call 8000 the smaller one
        op(R16, 1, 32'h0000_8000, 32'h0000_0010, 32'h0000_7FFF,
            0, 0, 0, 4'h8);
        op(R16, 1, 32'h0000_AB20, 32'h0000_0010, 32'h0000_AB1F,
            0, 0, 0, 4'h8);
        op(R16, 0, 32'h0000_0001, 32'h0000_0010, 32'h0000_AB1F,
            0, 0, 0, 4'h8);
        op(R16, 1, 32'h0000_0150, 32'h0000_0200, 32'h0000_0100,
            0, 0, 0, 4'h9);
        op(SGN, 1, 0, 0, 0, 16'hFFFF, 16'h0001, 0, 4'h2);
        op(SGN, 1, 0, 0, 0, 16'h7FFF, 16'h8000, 0, 4'h8);
        op(SGN, 1, 0, 0, 0, 16'h8000, 16'h8000, 0, 4'h4);
        op(SGN, 1, 0, 0, 0, 16'h0001, 16'h0002, 2'b01, 4'h5);
        op(R32, 1, 32'h0000_FFFF, 32'h0001_0000, 32'h8000_0000,
            0, 0, 0, 4'h2);
        op(R32, 1, 32'h0001_0000, 32'h0001_0000, 32'h8000_0000,
            0, 0, 0, 4'h4);
        op(R32, 1, 32'h8000_0001, 32'h0001_0000, 32'h8000_0000,
            0, 0, 0, 4'h8);
        op(R32, 1, 32'h0001_8000, 32'h0001_0000, 32'h8000_0000,
            0, 0, 2'b10, 4'h9);
        op(R32, 1, 32'h0001_8000, 32'h0002_0000, 32'h0001_FFFF,
            0, 0, 0, 4'h9);
        // Sticky events from above, masked so far
        check("irq masked", 0, 32'(irq));
        reg_read(cmp_pkg::REG_IRQSTAT, 16'h0003);
        reg_write(cmp_pkg::REG_IRQMASK, 16'h0003);
        op(R32, 1, 32'h0001_8000, 32'h0001_0000, 32'h8000_0000,
            0, 0, 0, 4'h4);
        check("irq raised", 1, 32'(irq));
        reg_read(cmp_pkg::REG_IRQSTAT, 16'h0001);
        @(posedge ref_clk);
        #1;
        check("irq cleared", 0, 32'(irq));
        reg_write(cmp_pkg::REG_IRQMASK, 16'h0002);
        op(SGN, 1, 0, 0, 0, 16'h0003, 16'h0002, 0, 4'h8);
        check("irq done masked", 0, 32'(irq));
        // Flags word is read-only
        reg_write(cmp_pkg::REG_FLAGS, 16'hFFFF);
        reg_read(cmp_pkg::REG_FLAGS, 16'h0020);
        // Moved code: old code is dead, new code runs the signed compare
        reg_write(cmp_pkg::REG_CODESGN, 16'h0200);
        op(SGN, 1, 0, 0, 0, 16'h0001, 16'h0001, 0, 4'h8);
        op(12'h200, 1, 0, 0, 0, 16'h0001, 16'h0001, 0, 4'h4);
        op(12'h115, 1, 0, 0, 0, 16'h0005, 16'h0001, 0, 4'h4);
        // Moved range code: the new code runs, the old one is dead
        reg_write(cmp_pkg::REG_CODE16, 16'h0300);
        reg_read(cmp_pkg::REG_CODE16, 16'h0300);
        op(12'h300, 1, 32'h0000_0020, 32'h0000_0001, 32'h0000_0009,
            0, 0, 0, 4'h8);
        op(R16, 1, 32'h0000_0001, 32'h0000_0005, 32'h0000_0009,
            0, 0, 0, 4'h8);
        // Frozen clock enable takes nothing
        clkEn <= 1'b0;
        op(12'h300, 1, 32'h0000_0001, 32'h0000_0010, 32'h0000_0020,
            0, 0, 0, 4'h8);
        clkEn <= 1'b1;
        @(posedge ref_clk);
        #1;
        check_flags(4'h8);
        tally_and_finish();
    end
endmodule : range_and_signed_compare_tb_top
